// [nqs_defs.svh]
`ifndef NQS_DEFS_SVH
`define NQS_DEFS_SVH
`define NQS_CLK_NS 4
`define NQS_TICK_NS 2000
`define NQS_TICK_CYC ((`NQS_TICK_NS) / (`NQS_CLK_NS))
`define NQS_WHOLE_TICKS 192
`define NQS_PATTERNS 100
`define NQS_SWING_LEVELS 6
`define NQS_OFF_CTRL 4'h0
`define NQS_OFF_MASK 4'h1
`define NQS_OFF_PSTART 4'h2
`define NQS_OFF_PEND 4'h3
`define NQS_OFF_LEN 4'h4
`define NQS_OFF_STATUS 4'h5
`define NQS_OFF_POS 4'h6
`define NQS_RST_GRID 4'h4
`define NQS_RST_LEN 16'h00C0
`define NQS_RST_MASK 15'h7FFF
`define NQS_RST_PEND 16'hFFFF
`endif

// [nqs_pkg.sv]
package nqs_pkg;
	typedef enum logic [3:0] {
		G4, G6, G8, G12, G16, G24, G32, G48, G64, G96, G192
	} nqs_grid_type;
	typedef enum logic [2:0] {
		PICK, HALT, SWING_SET, QUANT_SET, CLICK_SET, TEMPO_SET, LIVE_REC, GRID_ENT
	} nqs_state_type;
	function automatic logic [7:0] grid_den(input logic [3:0] g);
		logic [7:0] d;
		d = 8'h00;
		unique case (g)
			4'h0: d = 8'h04;
			4'h1: d = 8'h06;
			4'h2: d = 8'h08;
			4'h3: d = 8'h0C;
			4'h4: d = 8'h10;
			4'h5: d = 8'h18;
			4'h6: d = 8'h20;
			4'h7: d = 8'h30;
			4'h8: d = 8'h40;
			4'h9: d = 8'h60;
			default: d = 8'hC0;
		endcase
		return d;
	endfunction
	function automatic logic [7:0] grid_ticks(input logic [3:0] g);
		return 8'(16'hC0 / {8'h00, grid_den(g)});
	endfunction
	function automatic logic [6:0] swing_pct(input logic [2:0] l);
		logic [6:0] p;
		p = 7'h32;
		unique case (l)
			3'h1: p = 7'h36;
			3'h2: p = 7'h3A;
			3'h3: p = 7'h3F;
			3'h4: p = 7'h43;
			3'h5: p = 7'h47;
			default: p = 7'h32;
		endcase
		return p;
	endfunction
endpackage

// [nqs_top.sv]
// Our own choices: the address map and the address-and-strobe port.
`timescale 1ns/1ns
`include "nqs_defs.svh"
module nqs_top (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic [3:0] addr_i,
	input wire logic [15:0] wr_data_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [15:0] rd_data_o,
	input wire logic swing_key_i,
	input wire logic quant_key_i,
	input wire logic click_key_i,
	input wire logic tempo_key_i,
	input wire logic live_key_i,
	input wire logic grid_key_i,
	input wire logic halt_key_i,
	input wire logic inc_key_i,
	input wire logic dec_key_i,
	input wire logic frac_press_i,
	input wire logic [3:0] frac_code_i,
	input wire logic inst_press_i,
	input wire logic [3:0] inst_id_i,
	output logic [2:0] state_o,
	output logic [7:0] disp_value_o,
	output logic disp_off_o,
	output logic grid_mismatch_error_o,
	output logic note_wr_o,
	output logic [15:0] note_pos_o,
	output logic [3:0] note_inst_o,
	output logic [6:0] note_pat_o
);
	localparam int KN = 15;
	logic [KN-1:0] key_raw;
	logic [KN-1:0] key_s1;
	logic [KN-1:0] key_s2;
	logic [KN-1:0] key_s3;
	logic [KN-1:0] key_rise;
	logic [3:0] code_s1;
	logic [3:0] code_s2;
	logic [3:0] inst_s1;
	logic [3:0] inst_s2;
	assign key_raw = {inst_press_i, frac_press_i, dec_key_i, inc_key_i, halt_key_i,
		grid_key_i, live_key_i, tempo_key_i, click_key_i, quant_key_i, swing_key_i, 4'h0};
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			key_s1 <= '0;
			key_s2 <= '0;
			key_s3 <= '0;
			code_s1 <= 4'h0;
			code_s2 <= 4'h0;
			inst_s1 <= 4'h0;
			inst_s2 <= 4'h0;
		end else begin
			key_s1 <= key_raw;
			key_s2 <= key_s1;
			key_s3 <= key_s2;
			code_s1 <= frac_code_i;
			code_s2 <= code_s1;
			inst_s1 <= inst_id_i;
			inst_s2 <= inst_s1;
		end
	end
	assign key_rise = key_s2 & ~key_s3;
	logic k_swing, k_quant, k_click, k_tempo, k_live, k_grid, k_halt;
	logic k_inc, k_dec, k_frac, k_inst;
	assign k_swing = key_rise[4];
	assign k_quant = key_rise[5];
	assign k_click = key_rise[6];
	assign k_tempo = key_rise[7];
	assign k_live = key_rise[8];
	assign k_grid = key_rise[9];
	assign k_halt = key_rise[10];
	assign k_inc = key_rise[11];
	assign k_dec = key_rise[12];
	assign k_frac = key_rise[13];
	assign k_inst = key_rise[14];

	// software registers
	logic [6:0] pat;
	logic [14:0] inst_mask;
	logic [15:0] pass_start;
	logic [15:0] pass_end;
	logic [15:0] pat_len;
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			pat <= 7'h00;
			inst_mask <= `NQS_RST_MASK;
			pass_start <= 16'h0000;
			pass_end <= `NQS_RST_PEND;
			pat_len <= `NQS_RST_LEN;
		end else if (wr_i) begin
			unique case (addr_i)
				`NQS_OFF_CTRL: pat <= (wr_data_i[6:0] < 7'(`NQS_PATTERNS)) ? wr_data_i[6:0] : pat;
				`NQS_OFF_MASK: inst_mask <= wr_data_i[14:0];
				`NQS_OFF_PSTART: pass_start <= wr_data_i;
				`NQS_OFF_PEND: pass_end <= wr_data_i;
				`NQS_OFF_LEN: pat_len <= (wr_data_i == 16'h0000) ? 16'h0001 : wr_data_i;
				default: ;
			endcase
		end
	end

	// mode state
	nqs_pkg::nqs_state_type state;
	nqs_pkg::nqs_state_type next_state;
	logic [3:0] grid;
	logic [2:0] swing_mem [0:`NQS_PATTERNS-1];
	logic [2:0] cur_swing;
	logic mismatch;
	logic from_view;
	logic from_set;
	logic [6:0] swing_clr_cnt;
	assign cur_swing = swing_mem[pat];
	assign from_view = (state == nqs_pkg::PICK) || (state == nqs_pkg::HALT);
	assign from_set = (state == nqs_pkg::QUANT_SET) || (state == nqs_pkg::SWING_SET) ||
		(state == nqs_pkg::CLICK_SET) || (state == nqs_pkg::TEMPO_SET);
	assign mismatch = (cur_swing != 3'h0) && (grid != 4'h2) && (grid != 4'h4);
	always_comb begin
		next_state = state;
		unique case (state)
			nqs_pkg::PICK, nqs_pkg::HALT: begin
				if (k_swing)
					next_state = nqs_pkg::SWING_SET;
				else if (k_quant)
					next_state = nqs_pkg::QUANT_SET;
				else if (k_click)
					next_state = nqs_pkg::CLICK_SET;
				else if (k_tempo)
					next_state = nqs_pkg::TEMPO_SET;
				else if (k_live && !mismatch)
					next_state = nqs_pkg::LIVE_REC;
				else if (k_grid)
					next_state = nqs_pkg::GRID_ENT;
				else if (k_halt)
					next_state = (state == nqs_pkg::PICK) ? nqs_pkg::HALT : nqs_pkg::PICK;
			end
			nqs_pkg::SWING_SET: begin
				if (k_swing)
					next_state = nqs_pkg::PICK;
				else if (k_quant)
					next_state = nqs_pkg::QUANT_SET;
				else if (k_click)
					next_state = nqs_pkg::CLICK_SET;
				else if (k_tempo)
					next_state = nqs_pkg::TEMPO_SET;
			end
			nqs_pkg::QUANT_SET: begin
				if (k_quant)
					next_state = nqs_pkg::PICK;
				else if (k_swing)
					next_state = nqs_pkg::SWING_SET;
				else if (k_click)
					next_state = nqs_pkg::CLICK_SET;
				else if (k_tempo)
					next_state = nqs_pkg::TEMPO_SET;
			end
			nqs_pkg::CLICK_SET, nqs_pkg::TEMPO_SET: begin
				if (k_swing)
					next_state = nqs_pkg::SWING_SET;
				else if (k_quant)
					next_state = nqs_pkg::QUANT_SET;
				else if ((k_click && state == nqs_pkg::CLICK_SET) ||
					(k_tempo && state == nqs_pkg::TEMPO_SET))
					next_state = nqs_pkg::PICK;
				else if (k_click)
					next_state = nqs_pkg::CLICK_SET;
				else if (k_tempo)
					next_state = nqs_pkg::TEMPO_SET;
			end
			nqs_pkg::LIVE_REC, nqs_pkg::GRID_ENT: begin
				if (k_halt)
					next_state = nqs_pkg::PICK;
			end
		endcase
	end
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i)
			state <= nqs_pkg::PICK;
		else
			state <= next_state;
	end

	// grid and swing settings
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i)
			grid <= `NQS_RST_GRID;
		else if (state == nqs_pkg::QUANT_SET && k_frac && code_s2 <= 4'hA)
			grid <= code_s2;
	end
	// zero every pattern's swing level after reset
	always_ff @(posedge sys_clk_i) begin
		if (swing_clr_cnt < 7'(`NQS_PATTERNS))
			swing_mem[swing_clr_cnt] <= 3'h0;
		if (state == nqs_pkg::SWING_SET && k_inc && cur_swing < 3'(`NQS_SWING_LEVELS - 1))
			swing_mem[pat] <= cur_swing + 3'h1;
		else if (state == nqs_pkg::SWING_SET && k_dec && cur_swing != 3'h0)
			swing_mem[pat] <= cur_swing - 3'h1;
	end
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i)
			swing_clr_cnt <= 7'h00;
		else if (swing_clr_cnt < 7'(`NQS_PATTERNS))
			swing_clr_cnt <= swing_clr_cnt + 7'h01;
	end
	logic err;
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i)
			err <= 1'b0;
		else if (from_view && k_live && mismatch)
			err <= 1'b1;
		else if (!mismatch || !from_view)
			err <= 1'b0;
	end

	// tick base and position
	logic [9:0] div_cnt;
	logic tick_en;
	logic [15:0] pos;
	assign tick_en = (div_cnt == 10'(`NQS_TICK_CYC - 1));
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i)
			div_cnt <= 10'h000;
		else if (tick_en)
			div_cnt <= 10'h000;
		else
			div_cnt <= div_cnt + 10'h001;
	end
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i)
			pos <= 16'h0000;
		else if (state != nqs_pkg::LIVE_REC && state != nqs_pkg::GRID_ENT)
			pos <= 16'h0000;
		else if (state == nqs_pkg::LIVE_REC && tick_en)
			pos <= (pos + 16'h0001 >= pat_len) ? 16'h0000 : pos + 16'h0001;
		else if (state == nqs_pkg::GRID_ENT && k_inc)
			pos <= (pos + 16'(nqs_pkg::grid_ticks(grid)) >= pat_len) ? 16'h0000 :
				pos + 16'(nqs_pkg::grid_ticks(grid));
	end

	// snapping and swing
	logic [7:0] gt;
	logic [15:0] rem;
	logic [15:0] base;
	logic [15:0] snap;
	logic [15:0] slot;
	logic swing_on;
	logic [15:0] sdel;
	logic [15:0] live_pos;
	assign gt = nqs_pkg::grid_ticks(grid);
	assign rem = pos % {8'h00, gt};
	assign base = pos - rem;
	assign snap = ({rem[14:0], 1'b0} >= {8'h00, gt}) ? base + {8'h00, gt} : base;
	assign slot = snap / {8'h00, gt};
	assign swing_on = (grid == 4'h2 || grid == 4'h4) && inst_mask[inst_s2] &&
		(snap >= pass_start) && (snap <= pass_end) && slot[0];
	assign sdel = 16'(((32'(gt) * 32'(nqs_pkg::swing_pct(cur_swing)) * 32'h2) + 32'd50)
		/ 32'd100) - {8'h00, gt};
	always_comb begin
		live_pos = swing_on ? snap + sdel : snap;
		if (live_pos >= pat_len)
			live_pos = live_pos - pat_len;
	end

	// note writes; nothing here erases stored notes
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			note_wr_o <= 1'b0;
			note_pos_o <= 16'h0000;
			note_inst_o <= 4'h0;
			note_pat_o <= 7'h00;
		end else begin
			note_wr_o <= k_inst && (state == nqs_pkg::LIVE_REC || state == nqs_pkg::GRID_ENT);
			note_inst_o <= inst_s2;
			note_pat_o <= pat;
			if (state == nqs_pkg::LIVE_REC)
				note_pos_o <= live_pos;
			else
				note_pos_o <= pos;
		end
	end

	// display and status
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_o <= 3'h0;
			disp_value_o <= 8'h00;
			disp_off_o <= 1'b0;
			grid_mismatch_error_o <= 1'b0;
		end else begin
			state_o <= next_state;
			grid_mismatch_error_o <= err;
			disp_off_o <= (next_state == nqs_pkg::QUANT_SET) && (grid == 4'hA);
			if (next_state == nqs_pkg::SWING_SET)
				disp_value_o <= {1'b0, nqs_pkg::swing_pct(cur_swing)};
			else if (next_state == nqs_pkg::QUANT_SET)
				disp_value_o <= nqs_pkg::grid_den(grid);
			else
				disp_value_o <= {1'b0, pat};
		end
	end
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i)
			rd_data_o <= 16'h0000;
		else if (rd_i) begin
			unique case (addr_i)
				`NQS_OFF_CTRL: rd_data_o <= {9'h000, pat};
				`NQS_OFF_MASK: rd_data_o <= {1'b0, inst_mask};
				`NQS_OFF_PSTART: rd_data_o <= pass_start;
				`NQS_OFF_PEND: rd_data_o <= pass_end;
				`NQS_OFF_LEN: rd_data_o <= pat_len;
				`NQS_OFF_STATUS: rd_data_o <= {4'h0, err, cur_swing, grid, 1'b0, state};
				`NQS_OFF_POS: rd_data_o <= pos;
				default: rd_data_o <= 16'h0000;
			endcase
		end else
			rd_data_o <= 16'h0000;
	end

	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);
	swing_enter_a: assert property (from_view && k_swing |=> state == nqs_pkg::SWING_SET)
		else $error("swing key did not enter swing setting");
	swing_leave_a: assert property (state == nqs_pkg::SWING_SET && k_swing |=>
		state == nqs_pkg::PICK)
		else $error("swing key did not leave swing setting");
	quant_enter_a: assert property (from_set && k_quant && !k_swing &&
		state != nqs_pkg::QUANT_SET |=> state == nqs_pkg::QUANT_SET)
		else $error("quantize key did not enter quantize setting");
	quant_leave_a: assert property (state == nqs_pkg::QUANT_SET && k_quant |=>
		state == nqs_pkg::PICK)
		else $error("quantize key did not leave quantize setting");
	mismatch_err_a: assert property (from_view && k_live && mismatch |=>
		state != nqs_pkg::LIVE_REC ##1 grid_mismatch_error_o)
		else $error("mismatch not flagged on live entry");
	grid_step_a: assert property (note_wr_o && $past(state) == nqs_pkg::GRID_ENT |->
		note_pos_o % 16'($past(gt)) == 16'h0000)
		else $error("grid entry note off grid");
	live_snap_a: assert property (k_inst && state == nqs_pkg::LIVE_REC && !swing_on &&
		pat_len % {8'h00, gt} == 16'h0000 |=> note_pos_o % 16'($past(gt)) == 16'h0000)
		else $error("live note not snapped");
	swing_level_a: assert property (state == nqs_pkg::SWING_SET && k_inc &&
		cur_swing == 3'h5 |=> cur_swing == 3'h5)
		else $error("swing level passed top stage");
	swing_floor_a: assert property (state == nqs_pkg::SWING_SET && k_dec && !k_inc &&
		cur_swing == 3'h0 |=> cur_swing == 3'h0)
		else $error("swing level passed bottom stage");
	swing_step_a: assert property (state == nqs_pkg::SWING_SET && k_inc && !wr_i &&
		cur_swing < 3'h5 |=> cur_swing == $past(cur_swing) + 3'h1)
		else $error("swing level did not step up");
	swing_other_a: assert property (swing_clr_cnt == 7'(`NQS_PATTERNS) &&
		$past(pat) != 7'h00 |-> $stable(swing_mem[0]))
		else $error("other pattern swing changed");
	grid_code_a: assert property (state == nqs_pkg::QUANT_SET && k_frac &&
		code_s2 > 4'hA |=> grid == $past(grid))
		else $error("illegal grid code accepted");
	mask_block_a: assert property (k_inst && state == nqs_pkg::LIVE_REC &&
		!inst_mask[inst_s2] |=> note_pos_o == $past(snap) ||
		note_pos_o == $past(snap) - $past(pat_len))
		else $error("masked instrument was swung");
	swing_delay_a: assert property (k_inst && state == nqs_pkg::LIVE_REC && swing_on &&
		grid == 4'h4 && cur_swing == 3'h5 && snap + 16'h0005 < pat_len |=>
		note_pos_o == $past(snap) + 16'h0005)
		else $error("swing delay wrong at top level");
	off_disp_a: assert property (state == nqs_pkg::QUANT_SET && grid == 4'hA &&
		next_state == nqs_pkg::QUANT_SET |=> disp_off_o)
		else $error("grid off not shown");
	live_rec_c: cover property (state == nqs_pkg::LIVE_REC ##[1:200] note_wr_o);
	swing_use_c: cover property (k_inst && state == nqs_pkg::LIVE_REC && swing_on);
	mismatch_c: cover property (from_view && k_live && mismatch);
	set_hop_c: cover property (state == nqs_pkg::SWING_SET ##1 state == nqs_pkg::QUANT_SET);
	grid_note_c: cover property (note_wr_o && state == nqs_pkg::GRID_ENT);
endmodule

// [nqs_note_mem.sv]
`timescale 1ns/1ns
module nqs_note_mem (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic note_wr_i,
	input wire logic [15:0] note_pos_i,
	input wire logic [3:0] note_inst_i,
	input wire logic [6:0] note_pat_i,
	output logic [15:0] last_pos_o,
	output logic [3:0] last_inst_o,
	output logic [6:0] last_pat_o,
	output logic [7:0] count_o
);
	logic [26:0] mem [0:255];
	// each note goes to the next of 256 entries; the write index wraps and overwrites the oldest note
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			count_o <= 8'h00;
			last_pos_o <= 16'h0000;
			last_inst_o <= 4'h0;
			last_pat_o <= 7'h00;
		end else if (note_wr_i) begin
			mem[count_o] <= {note_pat_i, note_inst_i, note_pos_i};
			count_o <= count_o + 8'h01;
			last_pos_o <= note_pos_i;
			last_inst_o <= note_inst_i;
			last_pat_o <= note_pat_i;
		end
	end
endmodule

// [note_grid_quantize_swing_tb.sv]
`timescale 1ns/1ns
module note_grid_quantize_swing_tb;
	logic sys_clk_i, rst_i, wr_i, rd_i, frac_press_i, inst_press_i;
	logic [3:0] addr_i, frac_code_i, inst_id_i, note_inst, last_inst;
	logic [15:0] wr_data_i, rd_data_o, note_pos, last_pos, d, p;
	logic [8:0] key;
	logic [2:0] state_o;
	logic [7:0] disp_value_o, cnt;
	logic disp_off_o, err_o, note_wr;
	logic [6:0] note_pat, last_pat;
	logic [7:0] pct [0:5] = '{8'h32, 8'h36, 8'h3A, 8'h3F, 8'h43, 8'h47};
	int n_errors = 0;
	int tests_run = 0;
	nqs_top dut_u (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .addr_i(addr_i),
		.wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o),
		.swing_key_i(key[0]), .quant_key_i(key[1]), .click_key_i(key[2]),
		.tempo_key_i(key[3]), .live_key_i(key[4]), .grid_key_i(key[5]),
		.halt_key_i(key[6]), .inc_key_i(key[7]), .dec_key_i(key[8]),
		.frac_press_i(frac_press_i), .frac_code_i(frac_code_i),
		.inst_press_i(inst_press_i), .inst_id_i(inst_id_i), .state_o(state_o),
		.disp_value_o(disp_value_o), .disp_off_o(disp_off_o),
		.grid_mismatch_error_o(err_o), .note_wr_o(note_wr), .note_pos_o(note_pos),
		.note_inst_o(note_inst), .note_pat_o(note_pat));
	nqs_note_mem mem_u (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .note_wr_i(note_wr),
		.note_pos_i(note_pos), .note_inst_i(note_inst), .note_pat_i(note_pat),
		.last_pos_o(last_pos), .last_inst_o(last_inst), .last_pat_o(last_pat),
		.count_o(cnt));
	initial begin
		sys_clk_i = 1'b0;
		forever #2 sys_clk_i = ~sys_clk_i;
	end
	task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] v);
		@(posedge sys_clk_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wr_data_i <= v;
		@(posedge sys_clk_i);
		wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a);
		@(posedge sys_clk_i);
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge sys_clk_i);
		rd_i <= 1'b0;
		#1 d = rd_data_o;
	endtask
	task automatic press(input int k);
		@(posedge sys_clk_i);
		key[k] <= 1'b1;
		repeat (3) @(posedge sys_clk_i);
		key[k] <= 1'b0;
		repeat (5) @(posedge sys_clk_i);
		#1;
	endtask
	task automatic frac(input logic [3:0] c);
		@(posedge sys_clk_i);
		frac_code_i <= c;
		repeat (3) @(posedge sys_clk_i);
		frac_press_i <= 1'b1;
		repeat (3) @(posedge sys_clk_i);
		frac_press_i <= 1'b0;
		repeat (5) @(posedge sys_clk_i);
		#1;
	endtask
	task automatic hit(input logic [3:0] id);
		@(posedge sys_clk_i);
		inst_id_i <= id;
		repeat (3) @(posedge sys_clk_i);
		inst_press_i <= 1'b1;
		repeat (3) @(posedge sys_clk_i);
		inst_press_i <= 1'b0;
		repeat (6) @(posedge sys_clk_i);
		#1;
	endtask
	// wait for a fresh tick whose position has the wanted remainder
	task automatic wait_pos(input int m, input int r);
		rd(4'h6);
		p = d;
		for (int i = 0; i < 8000; i++) begin
			rd(4'h6);
			if (d !== p && (d % m) == r) break;
			p = d;
		end
		p = d;
	endtask
	task automatic t_regs();
		rd(4'h4);
		chk("len", d, 16'h00C0);
		rd(4'h1);
		chk("mask", d, 16'h7FFF);
		rd(4'h9);
		chk("unmapped", d, 16'h0000);
		rd(4'h5);
		chk("grid", {12'h000, d[7:4]}, 16'h0004);
	endtask
	task automatic t_swing();
		press(0);
		chk("swing enter", {13'h0000, state_o}, 16'h0002);
		repeat (6) press(8);
		chk("pct off", {8'h00, disp_value_o}, {8'h00, pct[0]});
		for (int i = 1; i < 6; i++) begin
			press(7);
			chk("pct", {8'h00, disp_value_o}, {8'h00, pct[i]});
		end
		press(0);
		chk("swing leave", {13'h0000, state_o}, 16'h0000);
		wr(4'h0, 16'h0002);
		press(0);
		repeat (6) press(8);
		press(0);
		wr(4'h0, 16'h0000);
		rd(4'h5);
		chk("own swing", {13'h0000, d[10:8]}, 16'h0005);
		press(0);
		chk("last set", {8'h00, disp_value_o}, {8'h00, pct[5]});
		press(0);
	endtask
	task automatic t_quant();
		press(1);
		chk("quant enter", {13'h0000, state_o}, 16'h0003);
		frac(4'hA);
		chk("off shown", {15'h0000, disp_off_o}, 16'h0001);
		frac(4'h0);
		chk("quarter", {8'h00, disp_value_o}, 16'h0004);
		chk("off gone", {15'h0000, disp_off_o}, 16'h0000);
		frac(4'hC);
		chk("bad code", {8'h00, disp_value_o}, 16'h0004);
		press(0);
		chk("direct swing", {13'h0000, state_o}, 16'h0002);
		press(1);
		chk("direct quant", {13'h0000, state_o}, 16'h0003);
		press(1);
		chk("quant leave", {13'h0000, state_o}, 16'h0000);
		press(4);
		chk("mismatch", {15'h0000, err_o}, 16'h0001);
		chk("live refused", {13'h0000, state_o}, 16'h0000);
		press(1);
		frac(4'h4);
		chk("mismatch gone", {15'h0000, err_o}, 16'h0000);
		press(1);
		for (int k = 2; k < 4; k++) begin
			press(k);
			chk("side mode", {13'h0000, state_o}, 16'(k + 2));
			press(0);
			chk("from side", {13'h0000, state_o}, 16'h0002);
			press(0);
		end
	endtask
	task automatic t_live();
		press(4);
		chk("live", {13'h0000, state_o}, 16'h0006);
		wait_pos(24, 6);
		hit(4'h3);
		chk("mid later swung", last_pos, p + 16'd11);
		chk("inst", {12'h000, last_inst}, 16'h0003);
		wr(4'h1, 16'h0000);
		wait_pos(24, 12);
		hit(4'h5);
		chk("masked out", last_pos, p);
		wr(4'h1, 16'h7FFF);
		wait_pos(24, 3);
		hit(4'h1);
		chk("snap odd", last_pos, p - 16'd3);
		press(6);
		chk("live leave", {13'h0000, state_o}, 16'h0000);
		press(5);
		chk("grid entry", {13'h0000, state_o}, 16'h0007);
		press(7);
		hit(4'h2);
		chk("no swing step", last_pos, 16'd12);
		chk("stored", {8'h00, cnt}, 16'h0004);
		chk("pattern", {9'h000, last_pat}, 16'h0000);
		press(6);
	endtask
	initial begin
		rst_i = 1'b1;
		wr_i = 1'b0;
		rd_i = 1'b0;
		addr_i = 4'h0;
		wr_data_i = 16'h0000;
		key = 9'h000;
		frac_press_i = 1'b0;
		frac_code_i = 4'h0;
		inst_press_i = 1'b0;
		inst_id_i = 4'h0;
		repeat (12) @(posedge sys_clk_i);
		rst_i <= 1'b0;
		t_regs();
		t_swing();
		t_quant();
		t_live();
		complete_run();
	end
	initial begin
		repeat (95000) @(posedge sys_clk_i);
		n_errors++;
		complete_run();
	end
endmodule
